// ### hdl/cmptmr_defs.svh
// Register map, field positions, reset values and prescaler taps for the
// compare timer. Assumes a byte-wide CPU peripheral bus with 16-bit address.
`ifndef CMPTMR_DEFS_SVH
`define CMPTMR_DEFS_SVH

`define CMPTMR_ADDR_CTRL 16'hffb6
`define CMPTMR_ADDR_STAT 16'hffb7
`define CMPTMR_ADDR_CNT_HI 16'hffb8
`define CMPTMR_ADDR_CNT_LO 16'hffb9
`define CMPTMR_ADDR_CMP_HI 16'hffba
`define CMPTMR_ADDR_CMP_LO 16'hffbb

`define CMPTMR_CTRL_RST 8'h00
`define CMPTMR_STAT_RST 8'h00
`define CMPTMR_CNT_RST 8'h00
`define CMPTMR_CMP_RST 8'hff
`define CMPTMR_BYTE_MAX 8'hff
`define CMPTMR_WO_READ 8'hff
`define CMPTMR_UNMAPPED_READ 8'h00

`define CMPTMR_TOL_HI 7
`define CMPTMR_CKSH_TOP 6
`define CMPTMR_CKSH_SEL 5:4
`define CMPTMR_TOL_LO 3
`define CMPTMR_CKSL_TOP 2
`define CMPTMR_CKSL_SEL 1:0

`define CMPTMR_OVF_HI 7
`define CMPTMR_CMF_HI 6
`define CMPTMR_OVIE_HI 5
`define CMPTMR_CCLR_HI 4
`define CMPTMR_OVF_LO 3
`define CMPTMR_CMF_LO 2
`define CMPTMR_OVIE_LO 1
`define CMPTMR_CCLR_LO 0
`define CMPTMR_FLAG_MASK 8'hcc

`define CMPTMR_TAP_DIV32 5'h1f
`define CMPTMR_TAP_DIV16 5'h0f
`define CMPTMR_TAP_DIV4 5'h03
`define CMPTMR_TAP_DIV2 5'h01

`endif

// ### hdl/cmptmr_pkg.sv
// Types shared by the compare timer files.
// Assumes the constants header supplies all numeric values.
package cmptmr_pkg;
  typedef logic [7:0] cmptmr_byte_t;
  // Prescaler tap codes, in the order of the two lower select bits.
  typedef enum logic [1:0]
  {
    CMPTMR_DIV32 = 2'h0,
    CMPTMR_DIV16 = 2'h1,
    CMPTMR_DIV4 = 2'h2,
    CMPTMR_DIV2 = 2'h3
  } cmptmr_div_t;
endpackage

// ### hdl/cmptmr_prescale.sv
// Free-running prescaler giving one-cycle ticks at phi/32, /16, /4, /2.
// Assumes one system clock and synchronous active-high reset.
`timescale 1ns/1ns
`include "cmptmr_defs.svh"
module cmptmr_prescale
(
  input logic ref_clk_in,
  input logic rst_in,
  output logic [3:0] tick_out
);
  localparam logic [4:0] TAPS [4] = '{`CMPTMR_TAP_DIV32, `CMPTMR_TAP_DIV16,
                                      `CMPTMR_TAP_DIV4, `CMPTMR_TAP_DIV2};
  logic [4:0] div_r;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      div_r <= 5'h00;
    else
      div_r <= div_r + 5'h01;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_tap
      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
          tick_out[i] <= 1'b0;
        else
          tick_out[i] <= (div_r & TAPS[i]) == TAPS[i];
      end
    end
  endgenerate
endmodule // cmptmr_prescale

// ### hdl/cmptmr_top.sv
// Compare timer: 16-bit counter or two 8-bit timers with compare match,
// toggle outputs and sticky flags on a byte-wide CPU register port.
// Assumes bus strobes are one-cycle pulses on ref_clk_in and the interrupt
// enable and edge-select bits come from registers on the same clock.
`timescale 1ns/1ns
`include "cmptmr_defs.svh"
module cmptmr_top
(
  input logic ref_clk_in,
  input logic rst_in,
  input logic [15:0] addr_in,
  input logic [7:0] wdata_in,
  input logic wr_in,
  input logic rd_in,
  output logic [7:0] rdata_out,
  input logic event_input_pin_in,
  input logic event_edge_select_in,
  input logic irq_enable_high_in,
  input logic irq_enable_low_in,
  output logic toggle_out_high_out,
  output logic toggle_out_low_out,
  output logic irq_request_high_out,
  output logic irq_request_low_out,
  output logic cpu_irq_high_out,
  output logic cpu_irq_low_out
);
  cmptmr_pkg::cmptmr_byte_t ctrl_r, stat_r, seen_r, temp_r;
  cmptmr_pkg::cmptmr_byte_t cnt_hi_r, cnt_lo_r, cmp_hi_r, cmp_lo_r;
  cmptmr_pkg::cmptmr_byte_t set_v, clr_v;
  cmptmr_pkg::cmptmr_div_t sel_hi, sel_lo;
  logic [3:0] tick;
  logic ev_s1_r, ev_s2_r, ev_s3_r, ev_edge;
  logic eq_h_prev_r, eq_l_prev_r;
  logic mode16, rd_stat, rd_cnt_hi;
  logic wr_ctrl, wr_stat, wr_cnt_hi, wr_cnt_lo, wr_cmp_hi, wr_cmp_lo;
  logic lo_tick, hi_step, hi_inc;
  logic eq_h, eq_l, match_h, match_l;
  logic clr_h, clr_l, ovf_h, ovf_l, req_h, req_l;

  cmptmr_prescale u_prescale
  (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // Address decode of the six byte registers.
  assign wr_ctrl = wr_in && (addr_in == `CMPTMR_ADDR_CTRL);
  assign wr_stat = wr_in && (addr_in == `CMPTMR_ADDR_STAT);
  assign wr_cnt_hi = wr_in && (addr_in == `CMPTMR_ADDR_CNT_HI);
  assign wr_cnt_lo = wr_in && (addr_in == `CMPTMR_ADDR_CNT_LO);
  assign wr_cmp_hi = wr_in && (addr_in == `CMPTMR_ADDR_CMP_HI);
  assign wr_cmp_lo = wr_in && (addr_in == `CMPTMR_ADDR_CMP_LO);
  assign rd_stat = rd_in && (addr_in == `CMPTMR_ADDR_STAT);
  assign rd_cnt_hi = rd_in && (addr_in == `CMPTMR_ADDR_CNT_HI);

  // mode from high select top bit
  assign mode16 = !ctrl_r[`CMPTMR_CKSH_TOP];
  assign sel_hi = cmptmr_pkg::cmptmr_div_t'(ctrl_r[`CMPTMR_CKSH_SEL]);
  assign sel_lo = cmptmr_pkg::cmptmr_div_t'(ctrl_r[`CMPTMR_CKSL_SEL]);

  // The pin is asynchronous; the third stage only serves edge detection so
  // the first stage is never looked at by logic.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end
    else
    begin
      ev_s1_r <= event_input_pin_in;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  assign ev_edge = event_edge_select_in ? (ev_s2_r && !ev_s3_r)
                                        : (!ev_s2_r && ev_s3_r);

  assign lo_tick = ctrl_r[`CMPTMR_CKSL_TOP] ? tick[sel_lo] : ev_edge;

  assign hi_step = mode16 ? lo_tick : tick[sel_hi];
  assign hi_inc = mode16 ? (cnt_lo_r == `CMPTMR_BYTE_MAX) : 1'b1;

  assign eq_h = mode16 ? ({cnt_hi_r, cnt_lo_r} == {cmp_hi_r, cmp_lo_r})
                       : (cnt_hi_r == cmp_hi_r);
  assign eq_l = !mode16 && (cnt_lo_r == cmp_lo_r);
  // A match is the moment equality begins, so a counter that sits on the
  // compare value for many cycles raises only one event.
  assign match_h = eq_h && !eq_h_prev_r;
  assign match_l = eq_l && !eq_l_prev_r;

  assign clr_h = stat_r[`CMPTMR_CCLR_HI] && eq_h;
  assign clr_l = mode16 ? clr_h : (stat_r[`CMPTMR_CCLR_LO] && eq_l);

  assign ovf_h = hi_step && hi_inc && !clr_h &&
                 (cnt_hi_r == `CMPTMR_BYTE_MAX);
  assign ovf_l = !mode16 && lo_tick && !clr_l &&
                 (cnt_lo_r == `CMPTMR_BYTE_MAX);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      eq_h_prev_r <= 1'b0;
      eq_l_prev_r <= 1'b0;
    end
    else
    begin
      eq_h_prev_r <= eq_h;
      eq_l_prev_r <= eq_l;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      ctrl_r <= `CMPTMR_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wdata_in;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      cnt_lo_r <= `CMPTMR_CNT_RST;
    else if (wr_cnt_lo)
      cnt_lo_r <= wdata_in;
    else if (lo_tick)
      cnt_lo_r <= clr_l ? `CMPTMR_CNT_RST : cnt_lo_r + 8'h01;
  end

  // high byte cascade; held upper byte
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      cnt_hi_r <= `CMPTMR_CNT_RST;
    else if (mode16 && wr_cnt_lo)
      cnt_hi_r <= temp_r;
    else if (!mode16 && wr_cnt_hi)
      cnt_hi_r <= wdata_in;
    else if (mode16 && wr_cnt_hi)
      cnt_hi_r <= cnt_hi_r;
    else if (hi_step && clr_h)
      cnt_hi_r <= `CMPTMR_CNT_RST;
    else if (hi_step && hi_inc)
      cnt_hi_r <= cnt_hi_r + 8'h01;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cmp_hi_r <= `CMPTMR_CMP_RST;
      cmp_lo_r <= `CMPTMR_CMP_RST;
    end
    else
    begin
      if (mode16 && wr_cmp_lo)
        cmp_hi_r <= temp_r;
      else if (!mode16 && wr_cmp_hi)
        cmp_hi_r <= wdata_in;
      if (wr_cmp_lo)
        cmp_lo_r <= wdata_in;
    end
  end

  // holding byte; latch on upper write, or on counter upper read
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      temp_r <= `CMPTMR_CNT_RST;
    else if (mode16 && (wr_cnt_hi || wr_cmp_hi))
      temp_r <= wdata_in;
    else if (mode16 && rd_cnt_hi)
      temp_r <= cnt_lo_r;
  end

  // Flags clear only when written 0 after being read as 1; a set in the
  // same cycle as the clear wins so no event is lost.
  assign set_v = {ovf_h, match_h, 2'b00, ovf_l, match_l, 2'b00};
  assign clr_v = wr_stat ? (~wdata_in & seen_r & `CMPTMR_FLAG_MASK)
                         : `CMPTMR_STAT_RST;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      stat_r <= `CMPTMR_STAT_RST;
    else
      stat_r <= ((set_v | (stat_r & ~clr_v)) & `CMPTMR_FLAG_MASK) |
                ((wr_stat ? wdata_in : stat_r) & ~`CMPTMR_FLAG_MASK);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      seen_r <= `CMPTMR_STAT_RST;
    else if (rd_stat)
      seen_r <= stat_r & `CMPTMR_FLAG_MASK;
    else
      seen_r <= seen_r & ~clr_v;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      toggle_out_high_out <= 1'b0;
    else if (wr_ctrl)
      toggle_out_high_out <= wdata_in[`CMPTMR_TOL_HI];
    else if (match_h)
      toggle_out_high_out <= !toggle_out_high_out;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      toggle_out_low_out <= 1'b0;
    else if (wr_ctrl)
      toggle_out_low_out <= wdata_in[`CMPTMR_TOL_LO];
    else if (match_l)
      toggle_out_low_out <= !toggle_out_low_out;
  end

  assign req_h = (ovf_h && stat_r[`CMPTMR_OVIE_HI]) || match_h;
  assign req_l = (ovf_l && stat_r[`CMPTMR_OVIE_LO]) || match_l;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      irq_request_high_out <= 1'b0;
      irq_request_low_out <= 1'b0;
      cpu_irq_high_out <= 1'b0;
      cpu_irq_low_out <= 1'b0;
    end
    else
    begin
      irq_request_high_out <= req_h;
      irq_request_low_out <= req_l;
      cpu_irq_high_out <= req_h && irq_enable_high_in;
      cpu_irq_low_out <= req_l && irq_enable_low_in;
    end
  end

  // read mux; counter lower byte from holding register in 16-bit mode
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      rdata_out <= `CMPTMR_UNMAPPED_READ;
    else if (rd_in)
    begin
      case (addr_in)
        `CMPTMR_ADDR_CTRL: rdata_out <= `CMPTMR_WO_READ;
        `CMPTMR_ADDR_STAT: rdata_out <= stat_r;
        `CMPTMR_ADDR_CNT_HI: rdata_out <= cnt_hi_r;
        `CMPTMR_ADDR_CNT_LO: rdata_out <= mode16 ? temp_r : cnt_lo_r;
        `CMPTMR_ADDR_CMP_HI: rdata_out <= cmp_hi_r;
        `CMPTMR_ADDR_CMP_LO: rdata_out <= cmp_lo_r;
        default: rdata_out <= `CMPTMR_UNMAPPED_READ;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  logic any_cnt_wr;
  assign any_cnt_wr = wr_cnt_hi || wr_cnt_lo;
  property p_reset_counts;
    $fell(rst_in) |-> (cnt_hi_r == 8'h00) && (cnt_lo_r == 8'h00);
  endproperty
  a_reset_counts: assert property (p_reset_counts)
    else $error("counter halves not zero after reset");
  property p_reset_compare;
    $fell(rst_in) |-> (cmp_hi_r == 8'hff) && (cmp_lo_r == 8'hff);
  endproperty
  a_reset_compare: assert property (p_reset_compare)
    else $error("compare halves not all ones after reset");
  property p_reset_ctrl;
    $fell(rst_in) |-> mode16 && !toggle_out_high_out && !toggle_out_low_out;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("control not at reset state after reset");
  property p_level_high;
    wr_ctrl |=> toggle_out_high_out == $past(wdata_in[`CMPTMR_TOL_HI]);
  endproperty
  a_level_high: assert property (p_level_high)
    else $error("high toggle output did not follow written level");
  property p_toggle_high;
    match_h && !wr_ctrl |=> toggle_out_high_out != $past(toggle_out_high_out);
  endproperty
  a_toggle_high: assert property (p_toggle_high)
    else $error("high toggle output did not invert on match");
  sequence s_wr_hi16;
    mode16 && wr_cnt_hi && !wr_ctrl;
  endsequence
  sequence s_wr_lo16;
    mode16 && wr_cnt_lo && !wr_ctrl;
  endsequence
  property p_pair_write;
    s_wr_hi16 ##1 (!wr_in && !rd_in) ##1 s_wr_lo16 |=>
      {cnt_hi_r, cnt_lo_r} == {$past(wdata_in, 3), $past(wdata_in)};
  endproperty
  a_pair_write: assert property (p_pair_write)
    else $error("16-bit counter write did not load both bytes");

  sequence s_rd_pair16;
    (mode16 && rd_cnt_hi && !wr_in) ##1 (!rd_in && !wr_in) ##1
      (mode16 && rd_in && addr_in == `CMPTMR_ADDR_CNT_LO && !wr_in);
  endsequence
  property p_pair_read;
    s_rd_pair16 |=> rdata_out == $past(cnt_lo_r, 3);
  endproperty
  a_pair_read: assert property (p_pair_read)
    else $error("lower byte read did not return latched value");

  property p_wrap16;
    mode16 && lo_tick && !clr_h && !any_cnt_wr &&
      {cnt_hi_r, cnt_lo_r} == 16'hffff
      |=> {cnt_hi_r, cnt_lo_r} == 16'h0000 && stat_r[`CMPTMR_OVF_HI];
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not clear counter and set flag");

  property p_clear16;
    mode16 && lo_tick && clr_h && !any_cnt_wr
      |=> {cnt_hi_r, cnt_lo_r} == 16'h0000;
  endproperty
  a_clear16: assert property (p_clear16)
    else $error("16-bit clear on match left counter nonzero");

  property p_hold;
    mode16 && !lo_tick && !any_cnt_wr |=> $stable({cnt_hi_r, cnt_lo_r});
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without a count enable");

  property p_match_flag;
    match_h |=> stat_r[`CMPTMR_CMF_HI] && irq_request_high_out;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match flag not set after compare match");
endmodule // cmptmr_top

// ### verif/cmptmr_cpu_model.sv
// CPU-side partner of the compare timer: byte bus master and event source.
// Assumes the bench calls its tasks and the timer takes strobes on posedge.
`timescale 1ns/1ns
module cmptmr_cpu_model
(
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic event_pin_out,
  output logic edge_sel_out,
  output logic ien_high_out,
  output logic ien_low_out
);
  initial
  begin
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    event_pin_out = 1'b0;
    edge_sel_out = 1'b1;
    ien_high_out = 1'b0;
    ien_low_out = 1'b0;
  end

  // byte access; released lines show the inverse, never a stale copy.
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask

  // upper byte first, lower byte completes the word.
  task automatic wr16(input logic [15:0] a_hi, input logic [15:0] v);
    bus_wr(a_hi, v[15:8]);
    bus_wr(a_hi + 16'h0001, v[7:0]);
  endtask

  task automatic set_ien(input logic h, input logic l);
    @(negedge ref_clk_in);
    ien_high_out = h;
    ien_low_out = l;
  endtask

  task automatic set_edge(input logic e);
    @(negedge ref_clk_in);
    edge_sel_out = e;
  endtask

  // the pin function never changes here; only the pin level moves.
  task automatic pulse_event(input int n);
    repeat (n)
    begin
      @(negedge ref_clk_in);
      event_pin_out = 1'b1;
      repeat (6) @(negedge ref_clk_in);
      event_pin_out = 1'b0;
      repeat (6) @(negedge ref_clk_in);
    end
  endtask
endmodule // cmptmr_cpu_model

// ### verif/tb_top.sv
// Self-checking bench for the compare timer, one task per scenario.
// Assumes the CPU model drives every bus and pin input on falling edges.
`timescale 1ns/1ns
`include "cmptmr_defs.svh"
module tb_top;
  localparam logic [15:0] A_CTL = `CMPTMR_ADDR_CTRL;
  localparam logic [15:0] A_ST = `CMPTMR_ADDR_STAT;
  localparam logic [15:0] A_CH = `CMPTMR_ADDR_CNT_HI;
  localparam logic [15:0] A_CL = `CMPTMR_ADDR_CNT_LO;
  localparam logic [15:0] A_MH = `CMPTMR_ADDR_CMP_HI;
  localparam logic [15:0] A_ML = `CMPTMR_ADDR_CMP_LO;
  logic ref_clk_in;
  logic rst_in;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr, rd, ev, esel, ien_h, ien_l;
  logic tog_h, tog_l, irq_h, irq_l, cpu_h, cpu_l;
  logic [7:0] rv;
  int err_count, num_checks, cyc, b, c;
  int n_hi, n_lo, n_cpu_hi, n_cpu_lo, d, gap_hi, gap_lo, last_hi, last_lo;

  cmptmr_top u_cmptmr_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .event_input_pin_in(ev),
    .event_edge_select_in(esel), .irq_enable_high_in(ien_h),
    .irq_enable_low_in(ien_l), .toggle_out_high_out(tog_h),
    .toggle_out_low_out(tog_l), .irq_request_high_out(irq_h),
    .irq_request_low_out(irq_l), .cpu_irq_high_out(cpu_h),
    .cpu_irq_low_out(cpu_l));

  cmptmr_cpu_model u_cmptmr_cpu_model (.ref_clk_in(ref_clk_in),
    .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .event_pin_out(ev), .edge_sel_out(esel),
    .ien_high_out(ien_h), .ien_low_out(ien_l));

  initial ref_clk_in = 1'b0;
  always #25 ref_clk_in = ~ref_clk_in;

  // Pulse counts and spacing, so request periods can be judged exactly.
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (irq_h === 1'b1)
    begin
      n_hi <= n_hi + 1;
      gap_hi <= cyc - last_hi;
      last_hi <= cyc;
    end
    if (irq_l === 1'b1)
    begin
      n_lo <= n_lo + 1;
      gap_lo <= cyc - last_lo;
      last_lo <= cyc;
    end
    if (cpu_h === 1'b1)
      n_cpu_hi <= n_cpu_hi + 1;
    if (cpu_l === 1'b1)
      n_cpu_lo <= n_cpu_lo + 1;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp,
    input string what);
    u_cmptmr_cpu_model.bus_rd(a, rv);
    check(what, rv, exp);
  endtask

  // A bound that runs out counts against the run and closes it.
  task automatic wait_irq(input bit hi, input int tgt);
    int k;
    for (k = 0; k < 3000 && (hi ? n_hi : n_lo) < tgt; k++)
      @(negedge ref_clk_in);
    if (k == 3000)
    begin
      err_count++;
      $display("MISMATCH request wait expected pulse seen none");
      final_report();
    end
  endtask

  task automatic t_reset;
    check("tog_hi", 8'(tog_h), 8'h00);
    check("tog_lo", 8'(tog_l), 8'h00);
    rchk(A_ST, 8'h00, "status");
    rchk(A_CH, 8'h00, "cnt_hi");
    rchk(A_CL, 8'h00, "cnt_lo");
    rchk(A_MH, 8'hff, "cmp_hi");
    rchk(A_ML, 8'hff, "cmp_lo");
    rchk(A_CTL, `CMPTMR_WO_READ, "ctrl");
    rchk(16'hffbc, `CMPTMR_UNMAPPED_READ, "unmapped");
  endtask

  task automatic t_holding;
    u_cmptmr_cpu_model.wr16(A_CH, 16'haa55);
    rchk(A_CH, 8'haa, "cnt16_hi");
    rchk(A_CL, 8'h55, "cnt16_lo");
    u_cmptmr_cpu_model.wr16(A_MH, 16'h1234);
    rchk(A_ML, 8'h34, "cmp16_lo");
    rchk(A_MH, 8'h12, "cmp16_hi");
  endtask

  task automatic t_toggle_level;
    u_cmptmr_cpu_model.bus_wr(A_CTL, 8'h88);
    check("tog_hi set", 8'(tog_h), 8'h01);
    check("tog_lo set", 8'(tog_l), 8'h01);
    u_cmptmr_cpu_model.bus_wr(A_CTL, 8'h08);
    check("tog_hi clr", 8'(tog_h), 8'h00);
    check("tog_lo keep", 8'(tog_l), 8'h01);
    u_cmptmr_cpu_model.bus_wr(A_CTL, 8'h00);
  endtask

  task automatic t_event16;
    u_cmptmr_cpu_model.set_ien(1'b1, 1'b1);
    // Lower high-select bits set while in 16-bit mode must be ignored.
    u_cmptmr_cpu_model.bus_wr(A_CTL, 8'h30);
    u_cmptmr_cpu_model.bus_wr(A_ST, 8'h10);
    u_cmptmr_cpu_model.wr16(A_MH, 16'h0103);
    u_cmptmr_cpu_model.wr16(A_CH, 16'h0100);
    b = n_hi;
    c = n_cpu_hi;
    u_cmptmr_cpu_model.pulse_event(3);
    rchk(A_CH, 8'h01, "ev_hi");
    rchk(A_CL, 8'h03, "ev_lo");
    check("match req", 8'(n_hi - b), 8'h01);
    check("match cpu", 8'(n_cpu_hi - c), 8'h01);
    check("tog_hi match", 8'(tog_h), 8'h01);
    rchk(A_ST, 8'h50, "match flag");
    u_cmptmr_cpu_model.pulse_event(1);
    rchk(A_CH, 8'h00, "clr_hi");
    rchk(A_CL, 8'h00, "clr_lo");
    // Falling edges only: the rising half of the pulse must not count.
    u_cmptmr_cpu_model.set_edge(1'b0);
    u_cmptmr_cpu_model.pulse_event(1);
    rchk(A_CH, 8'h00, "fall_hi");
    rchk(A_CL, 8'h01, "fall_edge");
    u_cmptmr_cpu_model.set_edge(1'b1);
    u_cmptmr_cpu_model.bus_wr(A_ST, 8'h10);
    rchk(A_ST, 8'h10, "flag cleared");
  endtask

  task automatic t_ovf16;
    u_cmptmr_cpu_model.bus_wr(A_ST, 8'h20);
    u_cmptmr_cpu_model.wr16(A_MH, 16'h0010);
    u_cmptmr_cpu_model.wr16(A_CH, 16'hfffe);
    b = n_hi;
    u_cmptmr_cpu_model.pulse_event(2);
    rchk(A_CH, 8'h00, "wrap_hi");
    rchk(A_CL, 8'h00, "wrap_lo");
    check("ovf req", 8'(n_hi - b), 8'h01);
    rchk(A_ST, 8'ha0, "ovf flag");
  endtask

  // Match period with clear enabled is (compare + 1) input periods.
  task automatic t_rates;
    int div [4] = '{32, 16, 4, 2};
    u_cmptmr_cpu_model.bus_wr(A_ST, 8'h11);
    for (int i = 0; i < 4; i++)
    begin
      u_cmptmr_cpu_model.bus_wr(A_CTL, 8'h44 | (8'(i) << 4) | 8'(i));
      u_cmptmr_cpu_model.bus_wr(A_MH, 8'h03);
      u_cmptmr_cpu_model.bus_wr(A_ML, 8'h03);
      u_cmptmr_cpu_model.bus_wr(A_CH, 8'h00);
      u_cmptmr_cpu_model.bus_wr(A_CL, 8'h00);
      b = n_hi;
      c = n_lo;
      d = n_cpu_lo;
      wait_irq(1'b0, c + 3);
      check("cpu lo", 8'(n_cpu_lo - d), 8'h03);
      check("period lo", 8'(gap_lo), 8'(4 * div[i]));
      wait_irq(1'b1, b + 3);
      check("period hi", 8'(gap_hi), 8'(4 * div[i]));
    end
  endtask

  task automatic t_ovf8;
    u_cmptmr_cpu_model.bus_wr(A_MH, 8'h80);
    u_cmptmr_cpu_model.bus_wr(A_ML, 8'h80);
    u_cmptmr_cpu_model.bus_wr(A_CH, 8'h00);
    u_cmptmr_cpu_model.bus_wr(A_CL, 8'h00);
    rchk(A_ST, 8'h55, "match flags 8bit");
    u_cmptmr_cpu_model.set_ien(1'b1, 1'b0);
    u_cmptmr_cpu_model.bus_wr(A_ST, 8'h02);
    u_cmptmr_cpu_model.bus_wr(A_CL, 8'hfd);
    b = n_lo;
    d = n_cpu_lo;
    repeat (20) @(negedge ref_clk_in);
    rchk(A_ST, 8'h0a, "ovf8 flag");
    check("ovf8 req", 8'(n_lo - b), 8'h01);
    check("ovf8 cpu gated", 8'(n_cpu_lo - d), 8'h00);
  endtask

  initial
  begin
    rst_in = 1'b1;
    repeat (12) @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_holding();
    t_toggle_level();
    t_event16();
    t_ovf16();
    t_rates();
    t_ovf8();
    final_report();
  end
endmodule // tb_top
